// *** cocm_pkg.sv ***
// Purpose: shared constants and types of the conversion on/off and margin control block
// Assumes: byte-wide command registers reached by command code over a transaction port
// Notes: conversion control and enable-source configuration bytes
//
// Overview of conversion_control
package cocm_pkg;
	// command codes
	localparam logic [7:0] CMD_CONV_CTRL = 8'h01;
	localparam logic [7:0] CMD_EN_CFG = 8'h02;
	// conversion control fields
	localparam int CTRL_ON_BIT = 7;
	localparam int CTRL_SOFT_BIT = 6;
	localparam int CTRL_MARGIN_HI = 5;
	localparam int CTRL_MARGIN_LO = 2;
	localparam logic [7:0] CTRL_RO_MASK = 8'h03;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// enable-source configuration fields
	localparam int CFG_PU_BIT = 4;
	localparam int CFG_CMD_BIT = 3;
	localparam int CFG_PIN_BIT = 2;
	localparam int CFG_POL_BIT = 1;
	localparam int CFG_DELAY_BIT = 0;
	localparam logic [7:0] CFG_RSVD_MASK = 8'he0;
	localparam logic [7:0] CFG_RESET = 8'h1e;
	// margin codes
	localparam logic [3:0] MRG_OFF0 = 4'h0;
	localparam logic [3:0] MRG_OFF1 = 4'h1;
	localparam logic [3:0] MRG_OFF2 = 4'h2;
	localparam logic [3:0] MRG_LOW_IGN = 4'h5;
	localparam logic [3:0] MRG_LOW_ACT = 4'h6;
	localparam logic [3:0] MRG_HIGH_IGN = 4'h9;
	localparam logic [3:0] MRG_HIGH_ACT = 4'ha;
	// target select
	localparam logic [1:0] TGT_NOMINAL = 2'h0;
	localparam logic [1:0] TGT_LOW = 2'h1;
	localparam logic [1:0] TGT_HIGH = 2'h2;
	// soft-off timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int TOFF_DELAY_NS = 1000;
	localparam int TOFF_FALL_NS = 1000;
	localparam int TOFF_DELAY_CYC = (TOFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOFF_FALL_CYC = (TOFF_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 16;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_SOFT = 2'b10
	} cocm_state_t;
endpackage

// *** cocm_offtimer.sv ***
// Purpose: turn-off delay then fall ramp timing for the soft-off profile
// Assumes: start is a one-cycle pulse; abort ends the sequence at once
// Notes: done pulses the cycle the ramp reaches zero
`timescale 1ns/1ps
module cocm_offtimer
	import cocm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// control
	input wire logic start,
	input wire logic abort,
	// status
	output logic holding,
	output logic falling,
	output logic done
);
	logic [TMR_W-1:0] cnt_reg;
	logic hold_end;
	logic fall_end;

	assign hold_end = holding && (cnt_reg == TMR_W'(TOFF_DELAY_CYC - 1));
	assign fall_end = falling && (cnt_reg == TMR_W'(TOFF_FALL_CYC - 1));

	always_ff @(posedge clk_sys) begin
		if (reset || abort) begin
			holding <= 1'b0;
			falling <= 1'b0;
			done <= 1'b0;
			cnt_reg <= '0;
		end else begin
			done <= fall_end;
			if (start) begin
				holding <= 1'b1;
				cnt_reg <= '0;
			end else if (hold_end) begin
				holding <= 1'b0;
				falling <= 1'b1;
				cnt_reg <= '0;
			end else if (fall_end) begin
				falling <= 1'b0;
				cnt_reg <= '0;
			end else if (holding || falling) begin
				cnt_reg <= cnt_reg + TMR_W'(1);
			end
		end
	end
endmodule

// *** cocm_top.sv ***
// Purpose: conversion on/off, turn-off profile and margin state control
// Assumes: bus framing is handled outside; one command byte per transaction strobe
// Notes: analog regulation and fault detectors live outside this block
`timescale 1ns/1ps
module cocm_top
	import cocm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// command transactions
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic rsp_error,
	// status and host notification
	input wire logic clear_status,
	output logic invalid_flag,
	output logic alert_n,
	// pins and prerequisites
	input wire logic enable_undervoltage_pin,
	input wire logic input_power_good,
	// power stage control
	output logic conv_run,
	output logic stage_hiz,
	output logic ramp_down,
	output logic [1:0] target_sel,
	output logic fault_ignore
);
	import cocm_pkg::*;

	// ****************************************
	// registers and decode
	// ****************************************
	logic [7:0] ctrl_reg;
	logic [7:0] cfg_reg;
	cocm_state_t state_reg;
	cocm_state_t state_next;
	logic [1:0] sync0_reg;
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic [1:0] level_reg;
	logic tmr_holding;
	logic tmr_falling;
	logic tmr_done;

	// returns {valid, ignore, target[1:0]}
	function automatic logic [3:0] margin_decode(input logic [3:0] code);
		case (code)
			MRG_OFF0, MRG_OFF1, MRG_OFF2: margin_decode = {2'b10, TGT_NOMINAL};
			MRG_LOW_IGN: margin_decode = {2'b11, TGT_LOW};
			MRG_LOW_ACT: margin_decode = {2'b10, TGT_LOW};
			MRG_HIGH_IGN: margin_decode = {2'b11, TGT_HIGH};
			MRG_HIGH_ACT: margin_decode = {2'b10, TGT_HIGH};
			default: margin_decode = {2'b00, TGT_NOMINAL};
		endcase
	endfunction

	wire [3:0] cur_margin = margin_decode(ctrl_reg[CTRL_MARGIN_HI:CTRL_MARGIN_LO]);
	wire [3:0] new_margin = margin_decode(cmd_wdata[CTRL_MARGIN_HI:CTRL_MARGIN_LO]);
	wire wr_ctrl = cmd_valid && cmd_write && (cmd_code == CMD_CONV_CTRL);
	wire wr_cfg = cmd_valid && cmd_write && (cmd_code == CMD_EN_CFG);
	wire mapped = (cmd_code == CMD_CONV_CTRL) || (cmd_code == CMD_EN_CFG);
	wire ctrl_ok = new_margin[3];
	wire cfg_ok = (cmd_wdata & CFG_RSVD_MASK) == 8'h00;
	wire bad_write = (wr_ctrl && !ctrl_ok) || (wr_cfg && !cfg_ok)
		|| (cmd_valid && !mapped);
	wire [7:0] rd_value = (cmd_code == CMD_CONV_CTRL) ? ctrl_reg :
		(cmd_code == CMD_EN_CFG) ? cfg_reg : 8'h00;

	// ****************************************
	// pin synchroniser
	// ****************************************
	// a level changes only once the second and third stages agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync0_reg <= 2'h0;
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			level_reg <= 2'h0;
		end else begin
			sync0_reg <= {input_power_good, enable_undervoltage_pin};
			sync1_reg <= sync0_reg;
			sync2_reg <= sync1_reg;
			level_reg <= (sync1_reg & sync2_reg) | (level_reg & (sync1_reg | sync2_reg));
		end
	end

	wire pin_level = level_reg[0];
	wire power_ok = level_reg[1];

	// ****************************************
	// enable source combination
	// ****************************************
	// pin honour and polarity
	wire pin_active = (pin_level == cfg_reg[CFG_POL_BIT]);
	// clear power-up bit ignores pin and bus
	wire pin_off = cfg_reg[CFG_PU_BIT] && cfg_reg[CFG_PIN_BIT] && !pin_active;
	wire cmd_off = cfg_reg[CFG_PU_BIT] && cfg_reg[CFG_CMD_BIT] && !ctrl_reg[CTRL_ON_BIT];
	// any honoured source off stops conversion
	wire want_on = !pin_off && !cmd_off;
	// immediate unless soft profile; pin-off profile from delay bit
	wire immediate_off = (cmd_off && !ctrl_reg[CTRL_SOFT_BIT])
		|| (pin_off && cfg_reg[CFG_DELAY_BIT]);

	// ****************************************
	// conversion state machine
	// ****************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// start needs power and every honoured source on
			ST_IDLE: begin
				if (want_on && power_ok) begin
					state_next = ST_RUN;
				end
			end
			// stop when a honoured source turns off
			ST_RUN: begin
				if (!power_ok || (!want_on && immediate_off)) begin
					state_next = ST_IDLE;
				end else if (!want_on) begin
					state_next = ST_SOFT;
				end
			end
			// halt when the ramp reaches zero
			ST_SOFT: begin
				if (tmr_done || !power_ok) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	wire tmr_start = (state_reg == ST_RUN) && (state_next == ST_SOFT);
	wire tmr_abort = (state_reg == ST_SOFT) && (state_next == ST_IDLE) && !tmr_done;

	cocm_offtimer u_offtimer (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(tmr_start),
		.abort(tmr_abort),
		.holding(tmr_holding),
		.falling(tmr_falling),
		.done(tmr_done)
	);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			conv_run <= 1'b0;
			stage_hiz <= 1'b1;
			ramp_down <= 1'b0;
		end else begin
			state_reg <= state_next;
			conv_run <= (state_next != ST_IDLE);
			stage_hiz <= (state_next == ST_IDLE);
			ramp_down <= tmr_falling && (state_next == ST_SOFT);
		end
	end

	// ****************************************
	// command registers and status
	// ****************************************
	// byte writes take effect at once; control resets to zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_reg <= CTRL_RESET;
			cfg_reg <= CFG_RESET;
		end else begin
			if (wr_ctrl && ctrl_ok) begin
				ctrl_reg <= cmd_wdata & ~CTRL_RO_MASK;
			end
			// configuration written only with valid data
			if (wr_cfg && cfg_ok) begin
				cfg_reg <= cmd_wdata;
			end
		end
	end

	// sticky invalid-data flag, a new event beats the clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			invalid_flag <= 1'b0;
			alert_n <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
			rsp_error <= 1'b0;
		end else begin
			invalid_flag <= bad_write || (invalid_flag && !clear_status);
			alert_n <= !(bad_write || (invalid_flag && !clear_status));
			rsp_valid <= cmd_valid;
			rsp_rdata <= (cmd_valid && !cmd_write) ? rd_value : 8'h00;
			rsp_error <= bad_write;
		end
	end

	// ****************************************
	// margin outputs
	// ****************************************
	// target and fault handling per margin code
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			target_sel <= TGT_NOMINAL;
			fault_ignore <= 1'b0;
		end else begin
			target_sel <= cur_margin[1:0];
			fault_ignore <= cur_margin[2] && ctrl_reg[CTRL_ON_BIT];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_ro_bits_zero: assert property ((ctrl_reg & CTRL_RO_MASK) == 8'h00)
		else $error("control low bits not zero");
	chk_reset_ctrl_zero: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset |=> (ctrl_reg == CTRL_RESET) && stage_hiz)
		else $error("control register not zero after reset");
	chk_invalid_write_flag: assert property ((wr_ctrl && !ctrl_ok)
		|=> invalid_flag && !alert_n && $stable(ctrl_reg))
		else $error("invalid control write not flagged");
	chk_start_prereq: assert property ($rose(conv_run)
		|-> $past(power_ok) && $past(want_on))
		else $error("conversion started without prerequisites");
	chk_pu_free_run: assert property ((state_reg == ST_RUN && power_ok
		&& !cfg_reg[CFG_PU_BIT]) |=> conv_run)
		else $error("conversion stopped with sources disabled");
	chk_cmd_ignored: assert property ((state_reg == ST_RUN && power_ok && cfg_reg[CFG_PU_BIT]
		&& !cfg_reg[CFG_CMD_BIT] && !pin_off) |=> conv_run)
		else $error("bus off acted on while ignored");
	chk_immediate_off: assert property ((state_reg == ST_RUN && cmd_off
		&& !ctrl_reg[CTRL_SOFT_BIT]) |=> !conv_run && stage_hiz && !ramp_down)
		else $error("immediate off not taken");
	chk_soft_off_ramp: assert property ((tmr_start && !cmd_valid)
		|=> conv_run && !ramp_down ##[9:12] ramp_down)
		else $error("soft off hold or ramp timing wrong");
	chk_pin_soft_off: assert property ((state_reg == ST_RUN && power_ok && pin_off && !cmd_off
		&& !cfg_reg[CFG_DELAY_BIT]) |=> conv_run)
		else $error("pin off not soft with delay bit clear");
	chk_margin_low_ign: assert property ((ctrl_reg[CTRL_MARGIN_HI:CTRL_MARGIN_LO] == MRG_LOW_IGN
		&& ctrl_reg[CTRL_ON_BIT])
		|=> fault_ignore && target_sel == TGT_LOW)
		else $error("low margin ignore not applied");
	chk_margin_high_act: assert property ((ctrl_reg[CTRL_MARGIN_HI:CTRL_MARGIN_LO] == MRG_HIGH_ACT)
		|=> !fault_ignore && target_sel == TGT_HIGH)
		else $error("high margin act not applied");

	cov_soft_off_done: cover property (tmr_done);
	cov_invalid_cfg: cover property (wr_cfg && !cfg_ok);
	cov_margin_high_ign: cover property (fault_ignore && target_sel == TGT_HIGH);
	cov_pin_start: cover property ($rose(conv_run) && cfg_reg[CFG_PIN_BIT]);
endmodule

// *** cocm_host_model.sv ***
// Purpose: host side of the command link, one byte per transfer
// Assumes: bus framing already stripped; transfers launched on the falling edge
// Notes: an idle cycle always separates two transfers
`timescale 1ns/1ps
module cocm_host_model (
	// clock
	clk_sys,
	// command transfer
	cmd_valid,
	cmd_write,
	cmd_code,
	cmd_wdata
);
	input wire logic clk_sys;
	output logic cmd_valid;
	output logic cmd_write;
	output logic [7:0] cmd_code;
	output logic [7:0] cmd_wdata;
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 8'h00;
	end
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data);
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = data;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// released lines flip so stale values are never mistaken for a request
		cmd_code = ~cmd_code;
		cmd_wdata = ~cmd_wdata;
	endtask
endmodule

// *** conversion_on_off_margin_control_tb.sv ***
// Purpose: self-checking bench for the conversion on/off and margin control
// Assumes: design timing as handed over; pins need a few edges to settle
// Notes: responses are checked against a queue of expected bytes
`timescale 1ns/1ps
module conversion_on_off_margin_control_tb;
	import cocm_pkg::*;
	logic clk_sys, reset, clear_status, en_pin, pgood, ok, seen_ramp;
	logic cmd_valid, cmd_write, rsp_valid, rsp_error, invalid_flag, alert_n;
	logic conv_run, stage_hiz, ramp_down, fault_ignore;
	logic [7:0] cmd_code, cmd_wdata, rsp_rdata, d_m, ctrl_m;
	logic [1:0] target_sel, tsel;
	logic [3:0] mc;
	logic [8:0] e_m;
	logic [8:0] exp_q[$];
	int n_mismatch, samples_checked;
	cocm_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
	cocm_top u_dut (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
		.clear_status(clear_status), .invalid_flag(invalid_flag), .alert_n(alert_n),
		.enable_undervoltage_pin(en_pin), .input_power_good(pgood), .conv_run(conv_run),
		.stage_hiz(stage_hiz), .ramp_down(ramp_down), .target_sel(target_sel),
		.fault_ignore(fault_ignore));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] code, input logic [7:0] d, input logic err);
		exp_q.push_back({err, 8'h00});
		u_host.xfer(1'b1, code, d);
	endtask
	task automatic rd(input logic [7:0] code, input logic [7:0] e, input logic err);
		exp_q.push_back({err, e});
		u_host.xfer(1'b0, code, 8'h00);
	endtask
	task automatic wait_run(input logic v, input int n);
		int i;
		for (i = 0; i < n && conv_run !== v; i++) @(negedge clk_sys);
		samples_checked++;
		if (conv_run !== v) begin
			n_mismatch++;
			$display("MISMATCH t=%0t run wait expired", $time);
			report_and_stop();
		end
	endtask
	// ***************************************
	// response monitor and watchdog
	// ***************************************
	always @(negedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			e_m = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
			chk(rsp_rdata, e_m[7:0]);
			chk({7'h0, rsp_error}, {7'h0, e_m[8]});
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		$display("MISMATCH t=%0t run too long", $time);
		report_and_stop();
	end
	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		reset = 1'b1;
		clear_status = 1'b0;
		en_pin = 1'b1;
		pgood = 1'b1;
		n_mismatch = 0;
		samples_checked = 0;
		void'($urandom(32'h05ed));
		repeat (12) @(negedge clk_sys);
		reset = 1'b0;
		rd(CMD_CONV_CTRL, 8'h00, 1'b0);
		rd(CMD_EN_CFG, CFG_RESET, 1'b0);
		chk({6'h0, conv_run, stage_hiz}, 8'h01);
		ctrl_m = 8'h00;
		for (int c = 0; c < 16; c++) begin
			mc = c[3:0];
			d_m = {2'b00, mc, 2'($urandom())};
			ok = mc inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
			wr(CMD_CONV_CTRL, d_m, !ok);
			if (ok) ctrl_m = {d_m[7:2], 2'b00};
			rd(CMD_CONV_CTRL, ctrl_m, 1'b0);
			tsel = ctrl_m[4] ? 2'h1 : (ctrl_m[5] ? 2'h2 : 2'h0);
			chk({6'h0, target_sel}, {6'h0, tsel});
		end
		chk({6'h0, invalid_flag, alert_n}, 8'h02);
		clear_status = 1'b1;
		@(negedge clk_sys);
		clear_status = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({6'h0, invalid_flag, alert_n}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			mc = i[1] ? (i[0] ? 4'ha : 4'h6) : (i[0] ? 4'h9 : 4'h5);
			wr(CMD_CONV_CTRL, {2'b10, mc, 2'b00}, 1'b0);
			wait_run(1'b1, 6);
			repeat (2) @(negedge clk_sys);
			chk({5'h0, fault_ignore, target_sel}, {5'h0, !i[1], (i[0] ? 2'h2 : 2'h1)});
		end
		wr(CMD_CONV_CTRL, 8'h00, 1'b0);
		wait_run(1'b0, 4);
		chk({7'h0, stage_hiz}, 8'h01);
		wr(CMD_CONV_CTRL, 8'h80, 1'b0);
		wait_run(1'b1, 6);
		wr(CMD_CONV_CTRL, 8'h40, 1'b0);
		seen_ramp = 1'b0;
		repeat (15) begin
			@(negedge clk_sys);
			seen_ramp = seen_ramp | (ramp_down === 1'b1);
		end
		chk({6'h0, conv_run, seen_ramp}, 8'h03);
		wait_run(1'b0, 12);
		wr(CMD_CONV_CTRL, 8'h80, 1'b0);
		wr(CMD_EN_CFG, 8'h1f, 1'b0);
		wait_run(1'b1, 6);
		en_pin = 1'b0;
		wait_run(1'b0, 8);
		wr(CMD_EN_CFG, 8'h1d, 1'b0);
		wait_run(1'b1, 8);
		wr(CMD_EN_CFG, 8'h1c, 1'b0);
		en_pin = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk({7'h0, conv_run}, 8'h01);
		wait_run(1'b0, 20);
		wr(CMD_CONV_CTRL, 8'h00, 1'b0);
		wr(CMD_EN_CFG, 8'h16, 1'b0);
		wait_run(1'b1, 8);
		wr(CMD_EN_CFG, 8'h06, 1'b0);
		en_pin = 1'b0;
		repeat (8) @(negedge clk_sys);
		chk({7'h0, conv_run}, 8'h01);
		pgood = 1'b0;
		wait_run(1'b0, 8);
		pgood = 1'b1;
		wait_run(1'b1, 8);
		wr(CMD_EN_CFG, 8'he6, 1'b1);
		rd(CMD_EN_CFG, 8'h06, 1'b0);
		rd(8'h03, 8'h00, 1'b1);
		repeat (3) @(negedge clk_sys);
		chk({6'h0, invalid_flag, alert_n}, 8'h02);
		chk(8'(exp_q.size()), 8'h00);
		report_and_stop();
	end
endmodule
